// File: include/cpu_bus_defines.svh
// Purpose: Shared constants of the processor bus controller
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
`ifndef CPU_BUS_DEFINES_SVH
`define CPU_BUS_DEFINES_SVH

// Bus widths
`define CPU_ADDR_W     16
`define CPU_DATA_W     8

// Reset values of the bus registers
`define CPU_ADDR_RST   16'h0000
`define CPU_DATA_RST   8'h00

`endif

// File: include/cpu_bus_pkg.sv
// Purpose: Types of the processor bus controller
// Assumes: Nothing beyond the defines header
// Notes:   Holds the sequencing states only
package cpu_bus_pkg;

    // Run state of the bus controller
    typedef enum logic [1:0] {
        ST_INIT,
        ST_RUN,
        ST_HALT,
        ST_WAIT
    } bus_state_t;

endpackage

// File: logic/cpu_bus_ctrl.sv
// Purpose: Bus control and release of an eight-bit processor
// Assumes: One bus cycle per sys_clk period, pins synchronous
// Notes:   Core side issues cycles; this block owns the pins
`timescale 1ns/1ps
`include "cpu_bus_defines.svh"

module cpu_bus_ctrl
    import cpu_bus_pkg::*;
#(
    parameter int ADDR_W = `CPU_ADDR_W,
    parameter int DATA_W = `CPU_DATA_W
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // Core cycle requests
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_data,
    // Core control
    input  wire logic              wait_exec,
    input  wire logic              irq_mask,
    input  wire logic              service_ack,
    output logic                   service_req,
    output logic                   nmi_pending,
    output logic                   core_start,
    output logic                   core_stopped,
    // Address bus and read/write pins
    output logic [ADDR_W-1:0]      addr_out,
    output logic                   addr_oe_n,
    output logic                   rw_out,
    output logic                   rw_oe_n,
    // Data bus pins
    input  wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0]      data_out,
    output logic                   data_oe_n,
    // Control and supervisory pins
    output logic                   valid_cycle_qualifier,
    output logic                   bus_available,
    input  wire logic              data_bus_drive_enable,
    input  wire logic              address_float_control,
    input  wire logic              halt_n,
    input  wire logic              irq_n,
    input  wire logic              nmi_n
);

    ////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (ADDR_W < 1 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W out of range");
    end
    if (DATA_W < 1 || DATA_W > 32) begin : g_bad_data
        $error("DATA_W out of range");
    end

    bus_state_t        st;
    bus_state_t        next_st;
    logic [ADDR_W-1:0] next_addr;
    logic              next_rw;
    logic              busy;
    logic              next_busy;
    logic [DATA_W-1:0] next_wdata;
    logic              next_rsp_valid;
    logic [DATA_W-1:0] next_rsp_data;
    logic              next_core_start;
    logic              take;
    logic              wait_go;
    logic              wake;
    logic              drive;

    ////////////////////////////////////////////////////////////////
    // Interrupt sensing
    irq_sense u_irq (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .irq_n       (irq_n),
        .nmi_n       (nmi_n),
        .irq_mask    (irq_mask),
        .service_ack (service_ack),
        .nmi_pending (nmi_pending),
        .service_req (service_req),
        .wake        (wake)
    );

    ////////////////////////////////////////////////////////////////
    // Request acceptance; halt blocks new cycles at once
    assign req_ready = (st == ST_RUN) && halt_n;
    assign take      = req_valid && req_ready;
    // A pending cycle request goes before the wait instruction
    assign wait_go   = wait_exec && req_ready && !req_valid;

    ////////////////////////////////////////////////////////////////
    // Run state sequencing
    always_comb begin
        next_st         = st;
        next_core_start = 1'b0;
        case (st)
            ST_INIT: begin
                next_st         = ST_RUN;
                next_core_start = 1'b1;
            end
            ST_RUN: begin
                if (!halt_n) begin
                    next_st = ST_HALT;
                end else if (wait_go) begin
                    next_st = ST_WAIT;
                end
            end
            ST_HALT: begin
                // Back to the stopped point, no restart pulse
                if (halt_n) begin
                    next_st = ST_RUN;
                end
            end
            ST_WAIT: begin
                if (wake) begin
                    next_st = ST_RUN;
                end
            end
            default: begin
                next_st = ST_INIT;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st         <= ST_INIT;
            core_start <= 1'b0;
        end else begin
            st         <= next_st;
            core_start <= next_core_start;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Bus cycle registers; idle cycles read with qualifier low
    always_comb begin
        next_addr  = addr_out;
        next_rw    = 1'b1;
        next_busy  = 1'b0;
        next_wdata = data_out;
        if (take) begin
            next_addr  = req_addr;
            next_rw    = !req_write;
            next_busy  = 1'b1;
            next_wdata = req_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_out <= ADDR_W'(`CPU_ADDR_RST);
            rw_out   <= 1'b1;
            busy     <= 1'b0;
            data_out <= DATA_W'(`CPU_DATA_RST);
        end else begin
            addr_out <= next_addr;
            rw_out   <= next_rw;
            busy     <= next_busy;
            data_out <= next_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read data taken at the end of each valid read cycle
    always_comb begin
        next_rsp_valid = busy && rw_out;
        next_rsp_data  = rsp_data;
        if (busy && rw_out) begin
            next_rsp_data = data_in;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_data  <= DATA_W'(`CPU_DATA_RST);
        end else begin
            rsp_valid <= next_rsp_valid;
            rsp_data  <= next_rsp_data;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Pin enables; stopped states release every three-state line
    assign drive     = (st == ST_RUN) || (st == ST_INIT);
    assign addr_oe_n = !drive || address_float_control;
    assign rw_oe_n   = !drive || address_float_control;
    // Writes only reach the pins inside the drive window
    assign data_oe_n = !(drive && busy && !rw_out && data_bus_drive_enable);

    // The qualifier is the cycle flop itself; stopped states clear it
    assign valid_cycle_qualifier = busy;
    // Tells alternate masters the pins are free
    assign bus_available = (st == ST_HALT) || (st == ST_WAIT);
    assign core_stopped  = bus_available;

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_cycle_cause;
        valid_cycle_qualifier |-> $past(req_valid) && $past(req_ready);
    endproperty
    a_cycle_cause: assert property (p_cycle_cause)
        else $error("qualifier without a taken request");

    property p_addr_match;
        (req_valid && req_ready) |=> valid_cycle_qualifier && addr_out == $past(req_addr);
    endproperty
    a_addr_match: assert property (p_addr_match)
        else $error("address not from request");

    property p_rw_dir;
        (req_valid && req_ready) |=> (rw_out == !$past(req_write)) && !rw_oe_n == !address_float_control;
    endproperty
    a_rw_dir: assert property (p_rw_dir)
        else $error("read/write wrong direction");

    property p_read_data;
        (valid_cycle_qualifier && rw_out) |=> rsp_valid && rsp_data == $past(data_in);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("read data not captured");

    property p_drive_gate;
        !data_bus_drive_enable |-> data_oe_n;
    endproperty
    a_drive_gate: assert property (p_drive_gate)
        else $error("data driven without enable");

    property p_float_ctl;
        address_float_control |-> addr_oe_n && rw_oe_n;
    endproperty
    a_float_ctl: assert property (p_float_ctl)
        else $error("address not floated");

    property p_halt_enter;
        (st == ST_RUN && !halt_n) |=> bus_available && !valid_cycle_qualifier && !req_ready;
    endproperty
    a_halt_enter: assert property (p_halt_enter)
        else $error("halt did not stop the core");

    property p_halt_float;
        (st == ST_HALT) |-> addr_oe_n && data_oe_n && rw_oe_n && !valid_cycle_qualifier && bus_available;
    endproperty
    a_halt_float: assert property (p_halt_float)
        else $error("halt state not released");

    property p_run_ba_low;
        (st == ST_RUN) |-> !bus_available;
    endproperty
    a_run_ba_low: assert property (p_run_ba_low)
        else $error("bus-available high while running");

    property p_wait_enter;
        (wait_exec && req_ready && !req_valid) |=> bus_available && addr_oe_n && data_oe_n;
    endproperty
    a_wait_enter: assert property (p_wait_enter)
        else $error("wait did not release bus");

    property p_halt_hold;
        (st == ST_HALT && !halt_n) |=> bus_available [*1] ##1 (bus_available || halt_n || $past(halt_n));
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("bus-available dropped during halt");

    property p_wait_wake;
        (st == ST_WAIT) |=> (bus_available == !$past(wake));
    endproperty
    a_wait_wake: assert property (p_wait_wake)
        else $error("wait exit wrong");

    property p_resume;
        (st == ST_HALT && halt_n) |=> !bus_available && !core_start && req_ready == halt_n;
    endproperty
    a_resume: assert property (p_resume)
        else $error("halt exit reinitialised");

    property p_start;
        (st == ST_INIT) |=> core_start ##1 !core_start;
    endproperty
    a_start: assert property (p_start)
        else $error("no start pulse after reset");

endmodule // cpu_bus_ctrl

// File: logic/irq_sense.sv
// Purpose: Interrupt request sensing for the processor
// Assumes: Inputs synchronous to sys_clk
// Notes:   Non-maskable request latched on its falling edge
`timescale 1ns/1ps

module irq_sense (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Request lines
    input  wire logic irq_n,
    input  wire logic nmi_n,
    // Core side
    input  wire logic irq_mask,
    input  wire logic service_ack,
    output logic      nmi_pending,
    output logic      service_req,
    output logic      wake
);

    logic nmi_prev;
    logic next_nmi_prev;
    logic next_nmi_pending;

    ////////////////////////////////////////////////////////////////
    // Edge latch; a new edge wins over an acknowledge
    always_comb begin
        next_nmi_prev    = nmi_n;
        next_nmi_pending = nmi_pending;
        if (service_ack) begin
            next_nmi_pending = 1'b0;
        end
        if (nmi_prev && !nmi_n) begin
            next_nmi_pending = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            nmi_prev    <= 1'b1;
            nmi_pending <= 1'b0;
        end else begin
            nmi_prev    <= next_nmi_prev;
            nmi_pending <= next_nmi_pending;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Mask gates only the maskable line
    assign service_req = nmi_pending || (!irq_n && !irq_mask);
    // Any request ends a wait, masked or not
    assign wake        = nmi_pending || !irq_n;

    property p_nmi_latch;
        @(posedge sys_clk) disable iff (!rst_n)
        (nmi_prev && !nmi_n) |=> (nmi_pending && service_req);
    endproperty
    a_nmi_latch: assert property (p_nmi_latch)
        else $error("nmi edge not latched");

endmodule // irq_sense

// File: sim/bus_memory_model.sv
// Purpose: Memory and peripheral model on the far side of the processor bus
// Assumes: One bus cycle per clock, pins sampled on the rising edge
// Notes:   Full 64K byte space; this bus has no wait states
`timescale 1ns/1ps

module bus_memory_model (
    // Clock
    input  wire logic        sys_clk,
    // Processor pins
    input  wire logic [15:0] addr_out,
    input  wire logic        addr_oe_n,
    input  wire logic        rw_out,
    input  wire logic        rw_oe_n,
    input  wire logic [7:0]  data_out,
    input  wire logic        data_oe_n,
    input  wire logic        valid_cycle_qualifier,
    // Data bus level seen by the processor
    output logic [7:0]       data_in
);
    logic [7:0] mem [0:65535];
    logic [7:0] last = 8'h00;
    logic       sel_rd;
    logic       sel_wr;

    ////////////////////////////////////////////////////////////////
    // Selected only with qualifier high and address really driven
    assign sel_rd = valid_cycle_qualifier & !addr_oe_n & !rw_oe_n & rw_out;
    assign sel_wr = valid_cycle_qualifier & !addr_oe_n & !rw_oe_n & !rw_out & !data_oe_n;

    // Released bus toggles, so stale data never passes for a match
    assign data_in = sel_rd ? mem[addr_out] : ~last;

    // Transfers land on the edge only, while address is stable
    always @(posedge sys_clk) begin
        last <= data_in;
        if (sel_wr) begin
            mem[addr_out] <= data_out;
        end
    end
endmodule // bus_memory_model

// File: sim/testbench.sv
// Purpose: Self-checking bench of the processor bus controller
// Assumes: Inputs change 2 ns after the rising edge
// Notes:   Table of plain transfers first, then halt, wait and interrupts
`timescale 1ns/1ps

module testbench;
    typedef struct packed { logic w; logic [15:0] a; logic [7:0] d; } row_t;
    logic sys_clk, rst_n, req_valid, req_write, req_ready, rsp_valid, wait_exec, irq_mask;
    logic service_ack, service_req, nmi_pending, core_start, core_stopped, addr_oe_n, rw_out;
    logic rw_oe_n, data_oe_n, valid_cycle_qualifier, bus_available, data_bus_drive_enable;
    logic address_float_control, halt_n, irq_n, nmi_n;
    logic [15:0] req_addr, addr_out;
    logic [7:0]  req_wdata, rsp_data, data_in, data_out;
    int          err_count = 0;
    int          checks = 0;
    int          n;
    row_t        rows [6] = '{'{1, 16'h0000, 8'h5A}, '{1, 16'hFFFF, 8'hA5}, '{1, 16'h1234, 8'h3C},
                              '{0, 16'h0000, 8'h5A}, '{0, 16'hFFFF, 8'hA5}, '{0, 16'h1234, 8'h3C}};

    cpu_bus_ctrl i_dut (.sys_clk, .rst_n, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready,
        .rsp_valid, .rsp_data, .wait_exec, .irq_mask, .service_ack, .service_req, .nmi_pending,
        .core_start, .core_stopped, .addr_out, .addr_oe_n, .rw_out, .rw_oe_n, .data_in, .data_out,
        .data_oe_n, .valid_cycle_qualifier, .bus_available, .data_bus_drive_enable,
        .address_float_control, .halt_n, .irq_n, .nmi_n);

    bus_memory_model i_mem (.sys_clk, .addr_out, .addr_oe_n, .rw_out, .rw_oe_n, .data_out,
        .data_oe_n, .valid_cycle_qualifier, .data_in);

    ////////////////////////////////////////////////////////////////
    // Clock, 20 ns period
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // Hang guard, well beyond the roughly 60 cycles of the run
    initial begin
        #100000;
        err_count++;
        conclude();
    end

    task automatic conclude();
        if (err_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Settle point 2 ns after an edge, where inputs also change
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #2;
    endtask

    task automatic wait_ready();
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            tick(1);
            n++;
        end
    endtask

    // One isolated transfer; for reads d is the expected data
    task automatic bus_op(input logic w, input logic [15:0] a, input logic [7:0] d);
        wait_ready();
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        tick(1);
        req_valid = 1'b0;
        chk("addr_out", a, addr_out);
        chk("rw_out", !w, rw_out);
        chk("qualifier", 1, valid_cycle_qualifier);
        chk("addr_oe_n", 0, addr_oe_n);
        chk("bus_available", 0, bus_available);
        if (w) begin
            chk("data_out", d, data_out);
            chk("data_oe_n", !data_bus_drive_enable, data_oe_n);
        end
        tick(1);
        chk("idle qualifier", 0, valid_cycle_qualifier);
        chk("idle rw_out", 1, rw_out);
        chk("idle data_oe_n", 1, data_oe_n);
        chk("rsp_valid", !w, rsp_valid);
        if (!w) begin
            chk("rsp_data", d, rsp_data);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst_n, req_valid, req_write, wait_exec, service_ack, address_float_control} = '0;
        {req_addr, req_wdata} = '0;
        {halt_n, irq_n, nmi_n, irq_mask, data_bus_drive_enable} = '1;
        tick(8);
        chk("reset addr", 16'h0000, addr_out);
        chk("reset qualifier", 0, valid_cycle_qualifier);
        chk("reset req_ready", 0, req_ready);
        rst_n = 1'b1;
        tick(1);
        chk("core_start", 1, core_start);
        tick(1);
        chk("core_start", 0, core_start);
        foreach (rows[i]) begin
            bus_op(rows[i].w, rows[i].a, rows[i].d);
        end
        // Write then read of the same byte, back to back
        req_valid = 1'b1;
        req_write = 1'b1;
        req_addr = 16'h8001;
        req_wdata = 8'hC3;
        tick(1);
        req_write = 1'b0;
        chk("b2b rw write", 0, rw_out);
        tick(1);
        req_valid = 1'b0;
        chk("b2b rw read", 1, rw_out);
        chk("b2b qualifier", 1, valid_cycle_qualifier);
        tick(1);
        chk("b2b rsp_data", 16'h00C3, rsp_data);
        // Write with drive enable low must not reach memory
        data_bus_drive_enable = 1'b0;
        bus_op(1, 16'h0000, 8'hFF);
        data_bus_drive_enable = 1'b1;
        bus_op(0, 16'h0000, 8'h5A);
        // Address float control
        address_float_control = 1'b1;
        tick(1);
        chk("float addr_oe_n", 1, addr_oe_n);
        chk("float rw_oe_n", 1, rw_oe_n);
        address_float_control = 1'b0;
        tick(1);
        chk("drive rw_oe_n", 0, rw_oe_n);
        // Halt with a request pending throughout
        halt_n = 1'b0;
        req_valid = 1'b1;
        req_write = 1'b0;
        tick(1);
        chk("halt ba", 1, bus_available);
        chk("halt oe", 3'b111, {addr_oe_n, rw_oe_n, data_oe_n});
        chk("halt stopped", 1, core_stopped);
        // Alternate master takes the bus only with every buffer released
        chk("alt master grant", 1, bus_available & addr_oe_n & rw_oe_n & data_oe_n);
        tick(5);
        chk("halt qualifier", 0, valid_cycle_qualifier);
        chk("halt ba held", 1, bus_available);
        req_valid = 1'b0;
        halt_n = 1'b1;
        tick(1);
        chk("resume ba", 0, bus_available);
        chk("resume start", 0, core_start);
        bus_op(0, 16'h1234, 8'h3C);
        // Wait instruction, woken by a masked request
        wait_exec = 1'b1;
        tick(1);
        wait_exec = 1'b0;
        chk("wait ba", 1, bus_available);
        chk("wait oe", 3'b111, {addr_oe_n, rw_oe_n, data_oe_n});
        tick(4);
        chk("wait ba held", 1, bus_available);
        irq_n = 1'b0;
        tick(1);
        chk("wake ba", 0, bus_available);
        chk("masked service", 0, service_req);
        irq_mask = 1'b0;
        tick(1);
        chk("unmasked service", 1, service_req);
        irq_n = 1'b1;
        irq_mask = 1'b1;
        // Non-maskable request wakes a wait even while masked
        tick(1);
        wait_exec = 1'b1;
        tick(1);
        wait_exec = 1'b0;
        nmi_n = 1'b0;
        n = 0;
        while (bus_available !== 1'b0 && n < 4) begin
            tick(1);
            n++;
        end
        chk("nmi wake ba", 0, bus_available);
        chk("nmi service", 1, service_req);
        service_ack = 1'b1;
        tick(1);
        service_ack = 1'b0;
        chk("nmi cleared", 0, nmi_pending);
        nmi_n = 1'b1;
        tick(2);
        // Second reset in mid-run; memory contents survive it
        rst_n = 1'b0;
        tick(2);
        chk("rerun ready", 0, req_ready);
        chk("rerun qualifier", 0, valid_cycle_qualifier);
        chk("rerun rw_out", 1, rw_out);
        chk("rerun nmi", 0, nmi_pending);
        rst_n = 1'b1;
        tick(1);
        chk("rerun start", 1, core_start);
        bus_op(0, 16'h1234, 8'h3C);
        conclude();
    end
endmodule // testbench
